// ===== src/standard_pwm_channel.sv
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "pwm_consts.svh"

module standard_pwm_channel
	import pwm_pkg::*;
#(
	parameter int N_TIMERS = 3   // Shared period timers
)
(
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,        // Low freezes all state
	input  wire logic        i_sleep,     // Device sleep, same clock
	input  wire logic        i_hsel,
	input  wire logic [7:0]  i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic             o_pwm_out,   // Output pin level
	output logic             o_pwm_oe     // Output pin enable
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	// The select field is two bits wide, so at most four timers
	generate
		if (N_TIMERS < 1 || N_TIMERS > 4)
		begin : g_bad_timers
			$error("N_TIMERS must lie between 1 and 4");
		end
	endgenerate

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a,
	                             input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	bus_state_e  bus_q;          // Bus slave state
	logic        wr_pend_q;      // Write data phase pending
	logic [7:0]  addr_q;         // Captured address
	logic [31:0] rd_d;           // Read mux
	logic        accept;         // Address phase taken
	logic        wr_en;          // Write commits this cycle
	byte_t       ctl_q;          // Module control
	byte_t       duty_high_q;    // Programmed high duty bits
	byte_t       duty_act_q;     // Active high duty bits
	logic [1:0]  duty_lat_q;     // Hidden low duty latch
	logic [1:0]  tsel_q;         // Timer select
	logic        dir_q;          // Pin direction, one is input
	logic [N_TIMERS-1:0] flag_q; // Timer match flags
	logic [1:0]  ps_q   [N_TIMERS];
	logic        run_q  [N_TIMERS];
	byte_t       lim_q  [N_TIMERS];
	byte_t       cnt    [N_TIMERS];
	logic [1:0]  sub    [N_TIMERS];
	logic [N_TIMERS-1:0] reload;
	logic [1:0]  sel_idx;        // Timer in use
	time_base_t  tb;             // Selected time base
	time_base_t  duty_prog;      // Duty as software wrote it
	time_base_t  duty_act;       // Duty in force this period
	logic        reload_sel;     // Period end of selected timer
	logic        run_ce;         // Module may advance
	logic        pwm_act;        // PWM mode selected
	logic        pwm_q;          // Output level
	logic        oe_q;           // Output enable
	logic        rdy_q;          // Bus ready
	logic [31:0] hrdata_q;       // Bus read data

	// Sleep stops the module but leaves the bus serviceable
	assign run_ce  = i_ce && !i_sleep;
	assign pwm_act = (ctl_q[`CTL_MODE_MSB:`CTL_MODE_LSB] == `MODE_PWM);
	assign accept  = i_hsel && i_htrans[1] && i_hready;
	assign wr_en   = i_ce && wr_pend_q;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Reads take one wait state so that a write just before is seen
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			bus_q <= BUS_IDLE;
		else if (i_ce)
		begin
			case (bus_q)
				BUS_IDLE, BUS_RD_DONE:
					bus_q <= (accept && !i_hwrite) ? BUS_RD_WAIT : BUS_IDLE;
				BUS_RD_WAIT:
					bus_q <= BUS_RD_DONE;
				default:
					bus_q <= BUS_IDLE;
			endcase
		end
	end

	// Address capture and write marker
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			addr_q    <= 8'h00;
			wr_pend_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (accept)
				addr_q <= i_haddr;
			// Only whole words are written
			wr_pend_q <= accept && i_hwrite && (i_hsize == `HSIZE_WORD);
		end
	end

	// Ready drops for the first data cycle of a read
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rdy_q    <= 1'b1;
			hrdata_q <= 32'h0000_0000;
		end
		else if (i_ce)
		begin
			rdy_q <= !(accept && !i_hwrite && bus_q != BUS_RD_WAIT);
			if (bus_q == BUS_RD_WAIT)
				hrdata_q <= rd_d;
		end
	end

	// Response is always OKAY
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			o_hresp <= 1'b0;
		else
			o_hresp <= 1'b0;
	end

	assign o_hreadyout = rdy_q;
	assign o_hrdata    = hrdata_q;

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (hit(addr_q, `OFS_CONTROL))
			rd_d = {24'h00_0000, ctl_q};
		else if (hit(addr_q, `OFS_DUTY_HIGH))
			rd_d = {24'h00_0000, duty_high_q};
		else if (hit(addr_q, `OFS_DUTY_BUF))
			rd_d = {24'h00_0000, duty_act_q};
		else if (hit(addr_q, `OFS_TSEL))
			rd_d = {30'h0000_0000, tsel_q};
		else if (hit(addr_q, `OFS_FLAGS))
			rd_d = 32'(flag_q);
		else if (hit(addr_q, `OFS_DIR))
			rd_d = {31'h0000_0000, dir_q};
		for (int k = 0; k < N_TIMERS; k++)
		begin
			if (hit(addr_q, `OFS_TIMER0 + 8'(4 * k)))
				rd_d = {8'h00, cnt[k], lim_q[k], 5'h00, run_q[k], ps_q[k]};
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Control holds mode and the two low duty bits
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			ctl_q <= `RST_CONTROL;
		else if (wr_en && hit(addr_q, `OFS_CONTROL))
			ctl_q <= {2'h0, i_hwdata[5:0]};
	end

	// High duty bits may be written at any time
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			duty_high_q <= `RST_DUTY;
		else if (wr_en && hit(addr_q, `OFS_DUTY_HIGH))
			duty_high_q <= i_hwdata[7:0];
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			tsel_q <= `RST_TSEL;
		else if (wr_en && hit(addr_q, `OFS_TSEL))
			tsel_q <= i_hwdata[1:0];
	end

	// Pin starts as input so nothing drives until software asks
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			dir_q <= `RST_DIR;
		else if (wr_en && hit(addr_q, `OFS_DIR))
			dir_q <= i_hwdata[0];
	end

	// ----------------------------------------
	// Period timers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_TIMERS; g++)
		begin : g_timer
			// Run, prescale and period limit of one timer
			always_ff @(posedge i_clk or posedge i_reset)
			begin
				if (i_reset)
				begin
					ps_q[g]  <= `RST_PS;
					run_q[g] <= 1'b0;
					lim_q[g] <= `RST_LIMIT;
				end
				else if (wr_en && hit(addr_q, `OFS_TIMER0 + 8'(4 * g)))
				begin
					ps_q[g]  <= i_hwdata[`TCTL_PS_MSB:`TCTL_PS_LSB];
					run_q[g] <= i_hwdata[`TCTL_RUN_BIT];
					lim_q[g] <= i_hwdata[`TCTL_LIM_MSB:`TCTL_LIM_LSB];
				end
			end

			period_timer u_timer
			(
				.i_clk      (i_clk),
				.i_reset    (i_reset),
				.i_ce       (run_ce),
				.i_run      (run_q[g]),
				.i_prescale (ps_q[g]),
				.i_limit    (lim_q[g]),
				.o_count    (cnt[g]),
				.o_sub      (sub[g]),
				.o_reload   (reload[g])
			);

			// Flag is write-one-to-clear; a new match wins
			always_ff @(posedge i_clk or posedge i_reset)
			begin
				if (i_reset)
					flag_q[g] <= 1'b0;
				else if (reload[g])
					flag_q[g] <= 1'b1;
				else if (wr_en && hit(addr_q, `OFS_FLAGS) && i_hwdata[g])
					flag_q[g] <= 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Time base and duty
	// ----------------------------------------
	// A select beyond the fitted timers falls back to timer zero
	assign sel_idx    = (tsel_q < N_TIMERS) ? tsel_q : 2'h0;
	assign tb         = {cnt[sel_idx], sub[sel_idx]};
	assign reload_sel = reload[sel_idx];
	assign duty_prog  = {duty_high_q, ctl_q[`CTL_DLOW_MSB:`CTL_DLOW_LSB]};
	assign duty_act   = {duty_act_q, duty_lat_q};

	// Active buffer: period match only in PWM mode, software otherwise
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			duty_act_q <= `RST_DUTY;
			duty_lat_q <= 2'h0;
		end
		else if (pwm_act)
		begin
			if (run_ce && reload_sel)
			begin
				duty_act_q <= duty_high_q;
				duty_lat_q <= ctl_q[`CTL_DLOW_MSB:`CTL_DLOW_LSB];
			end
		end
		// Sleep drops software writes so that the frozen buffer holds
		else if (wr_en && !i_sleep && hit(addr_q, `OFS_DUTY_BUF))
			duty_act_q <= i_hwdata[7:0];
	end

	// ----------------------------------------
	// Output level
	// ----------------------------------------
	// Set at wrap unless the programmed duty is zero, cleared on a ten-bit match or outside PWM mode; otherwise no change
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			pwm_q <= 1'b0;
		else if (run_ce)
		begin
			if (!pwm_act)
				pwm_q <= 1'b0;
			else if (reload_sel)
				pwm_q <= (duty_prog != 10'h000);
			else if (tb == duty_act)
				pwm_q <= 1'b0;
		end
	end

	// Drive only with direction cleared and control nonzero
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			oe_q <= 1'b0;
		else if (i_ce)
			oe_q <= !dir_q && (ctl_q != 8'h00);
	end

	assign o_pwm_out = pwm_q;
	assign o_pwm_oe  = oe_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pin_set:
	assert property (run_ce && pwm_act && reload_sel &&
		duty_prog != 10'h000 |=> pwm_q)
		else $error("pin not set at period start");

	a_zero_duty:
	assert property (run_ce && pwm_act && reload_sel &&
		duty_prog == 10'h000 |=> !pwm_q)
		else $error("pin set with zero duty");

	a_buf_latch:
	assert property (run_ce && pwm_act && reload_sel |=>
		duty_act == $past(duty_prog))
		else $error("duty not latched at period match");

	a_buf_hold:
	assert property (pwm_act && !(run_ce && reload_sel) |=>
		$stable(duty_act))
		else $error("active duty changed mid period");

	a_match_clear:
	assert property (run_ce && pwm_act && !reload_sel &&
		tb == duty_act |=> !pwm_q)
		else $error("pin not cleared on duty match");

	a_no_match:
	assert property (run_ce && pwm_act && !reload_sel &&
		tb != duty_act |=> $stable(pwm_q))
		else $error("pin changed without a match");

	a_sleep_hold:
	assert property (!run_ce |=> $stable(pwm_q) && $stable(duty_act))
		else $error("state moved during sleep");

	a_flag_set:
	assert property (reload[0] |=> flag_q[0])
		else $error("match flag not set");

	a_release:
	assert property (i_ce && ctl_q == 8'h00 |=> !o_pwm_oe)
		else $error("pin still driven with control cleared");

	a_read_wait:
	assert property (i_ce && accept && !i_hwrite && bus_q != BUS_RD_WAIT
		##1 i_ce |-> !o_hreadyout ##1 o_hreadyout)
		else $error("read wait state wrong");

	c_full_pulse:
	cover property (pwm_act && pwm_q ##1 !pwm_q);

	c_zero_duty:
	cover property (pwm_act && reload_sel && duty_prog == 10'h000);

	c_sleep_wake:
	cover property (pwm_q && i_sleep ##1 !i_sleep);

endmodule : standard_pwm_channel

// ===== common/pwm_consts.svh
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CONTROL   8'h00
`define OFS_DUTY_HIGH 8'h04
`define OFS_DUTY_BUF  8'h08
`define OFS_TSEL      8'h0C
`define OFS_FLAGS     8'h10
`define OFS_DIR       8'h14
// Timer n control sits at OFS_TIMER0 + 4*n
`define OFS_TIMER0    8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_MODE_MSB  3
`define CTL_MODE_LSB  0
`define CTL_DLOW_MSB  5
`define CTL_DLOW_LSB  4
`define TCTL_RUN_BIT  2
`define TCTL_PS_MSB   1
`define TCTL_PS_LSB   0
`define TCTL_LIM_MSB  15
`define TCTL_LIM_LSB  8

// ----------------------------------------
// Encodings
// ----------------------------------------
`define MODE_PWM      4'hC
`define PS_1          2'h0
`define PS_4          2'h1
`define HSIZE_WORD    3'h2

// ----------------------------------------
// Timing counts: oscillator cycles per timer step, minus one
// ----------------------------------------
`define PRE_LAST_1    6'h03
`define PRE_LAST_4    6'h0F
`define PRE_LAST_16   6'h3F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONTROL   8'h00
`define RST_DUTY      8'h00
`define RST_TSEL      2'h0
`define RST_DIR       1'b1
`define RST_LIMIT     8'hFF
`define RST_PS        2'h0

`endif

// ===== common/pwm_pkg.sv
package pwm_pkg;

	// Bus slave sequencing, Gray coded along idle, wait, done
	typedef enum logic [1:0]
	{
		BUS_IDLE    = 2'h0,
		BUS_RD_WAIT = 2'h1,
		BUS_RD_DONE = 2'h3
	} bus_state_e;

	typedef logic [9:0] time_base_t;   // Timer count plus two sub bits
	typedef logic [7:0] byte_t;

endpackage : pwm_pkg

// ===== src/period_timer.sv
`timescale 1ns/1ps
`include "pwm_consts.svh"

module period_timer
	import pwm_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_ce,       // Low freezes count and prescaler
	input  wire logic       i_run,      // Timer run bit
	input  wire logic [1:0] i_prescale, // Prescale select
	input  wire logic [7:0] i_limit,    // Period limit
	output byte_t           o_count,    // Period timer count
	output logic [1:0]      o_sub,      // Low bits of the time base
	output logic            o_reload    // Step that wraps the count
);

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	// Last prescaler value for each factor 1, 4, 16
	function automatic logic [5:0] pre_last(input logic [1:0] ps);
		case (ps)
			`PS_1:   pre_last = `PRE_LAST_1;
			`PS_4:   pre_last = `PRE_LAST_4;
			default: pre_last = `PRE_LAST_16;
		endcase
	endfunction : pre_last

	logic [5:0] pre_q;   // Oscillator cycles within one timer step
	logic       inc;     // Timer step strobe

	assign inc      = i_ce && i_run && (pre_q == pre_last(i_prescale));
	assign o_reload = inc && (o_count == i_limit);

	// Sub bits: oscillator phase at 1:1, upper prescaler bits otherwise
	always_comb
	begin
		case (i_prescale)
			`PS_1:   o_sub = pre_q[1:0];
			`PS_4:   o_sub = pre_q[3:2];
			default: o_sub = pre_q[5:4];
		endcase
	end

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// Holds while stopped so a restart resumes mid-step
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			pre_q <= 6'h00;
		else if (inc)
			pre_q <= 6'h00;
		else if (i_ce && i_run)
			pre_q <= pre_q + 6'h01;
	end

	// ----------------------------------------
	// Period count
	// ----------------------------------------
	// Wrap on the step after equality; postscaler plays no part
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			o_count <= 8'h00;
		else if (o_reload)
			o_count <= 8'h00;
		else if (inc)
			o_count <= o_count + 8'h01;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_prescale_gap:
	assert property (@(posedge i_clk) disable iff (i_reset)
		inc |=> !inc [*3])
		else $error("timer stepped faster than four cycles");

	a_wrap_zero:
	assert property (@(posedge i_clk) disable iff (i_reset)
		o_reload |=> (o_count == 8'h00))
		else $error("count not cleared after period match");

endmodule : period_timer

// ===== tb/pwm_load.sv
`timescale 1ns/1ps

// ----------------------------------------
// Load on the output pin, with a pull-down
// ----------------------------------------
module pwm_load
(
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_out,     // Level driven by the channel
	input  wire logic i_oe,      // Drive enable of the channel
	output logic      o_pin,     // Resolved pin level
	output int        o_high,    // Cycles high in the last pulse
	output int        o_period   // Cycles between the last two rises
);
	logic last_q;                // Pin level one cycle ago
	int   run_q;                 // Cycles since the last rise
	int   hi_q;                  // Cycles high so far

	// A released pin falls to the pull-down, never a stale level
	assign o_pin = i_oe ? i_out : 1'b0;

	// Edge timing of the pin, as a scope on the load would see it
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			last_q   <= 1'b0;
			run_q    <= 0;
			hi_q     <= 0;
			o_high   <= 0;
			o_period <= 0;
		end
		else
		begin
			last_q <= o_pin;
			run_q  <= (o_pin && !last_q) ? 1 : run_q + 1;
			hi_q   <= o_pin ? hi_q + 1 : 0;
			if (o_pin && !last_q)
				o_period <= run_q;
			if (!o_pin && last_q)
				o_high <= hi_q;
		end
	end
endmodule : pwm_load

// ===== tb/standard_pwm_channel_tb_top.sv
`timescale 1ns/1ps
`include "pwm_consts.svh"

module standard_pwm_channel_tb_top
	import pwm_pkg::*;
;
	logic        clk       = 1'b0;
	logic        reset     = 1'b1;
	logic        ce        = 1'b1;   // Low stalls the whole block
	logic        sleep     = 1'b0;
	logic        hsel      = 1'b0;
	logic [7:0]  haddr     = 8'h00;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [31:0] hwdata    = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        pwm_out;
	logic        pwm_oe;
	logic        pin;
	int          high_seen;
	int          period_seen;
	int          fails       = 0;
	int          comparisons = 0;
	int          cycles      = 0;
	int          seed        = 91;
	int          fac[4]      = '{1, 4, 16, 16};
	logic [7:0]  ra[8]       = '{`OFS_CONTROL, `OFS_DUTY_HIGH, `OFS_DUTY_BUF,
		`OFS_TSEL, `OFS_FLAGS, `OFS_DIR, `OFS_TIMER0, 8'h18};
	logic [31:0] rv[8]       = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1,
		32'h0000FF00, 32'h0};

	always #25 clk = ~clk;

	standard_pwm_channel i_dut
	(
		.i_clk       (clk),
		.i_reset     (reset),
		.i_ce        (ce),
		.i_sleep     (sleep),
		.i_hsel      (hsel),
		.i_haddr     (haddr),
		.i_htrans    (htrans),
		.i_hwrite    (hwrite),
		.i_hsize     (`HSIZE_WORD),
		.i_hwdata    (hwdata),
		.i_hready    (hreadyout),
		.o_hrdata    (hrdata),
		.o_hreadyout (hreadyout),
		.o_hresp     (hresp),
		.o_pwm_out   (pwm_out),
		.o_pwm_oe    (pwm_oe)
	);

	pwm_load i_load
	(
		.i_clk    (clk),
		.i_reset  (reset),
		.i_out    (pwm_out),
		.i_oe     (pwm_oe),
		.o_pin    (pin),
		.o_high   (high_seen),
		.o_period (period_seen)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	// One single transfer; the master waits on hready, never on a count
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
		check("hresp", 32'(hresp), 32'h0);
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		ahb(1'b0, a, 32'h0, q);
	endtask : rd

	task automatic rst(input int n);
		reset <= 1'b1;
		repeat (n) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask : rst

	function automatic logic [7:0] tmr(input logic [1:0] n);
		return `OFS_TIMER0 + {4'h0, n, 2'h0};
	endfunction : tmr

	function automatic int exp_period(input int lim, input int ps);
		return (lim + 1) * 4 * fac[ps];
	endfunction : exp_period

	// Advised bring-up order, pin driver enabled last
	task automatic setup(input logic [1:0] n, input logic [1:0] ps,
		input logic [7:0] lim, input logic [9:0] duty);
		logic [31:0] q;
		rst(2);
		wr(`OFS_TSEL, {30'h0, n});
		wr(tmr(n), {16'h0, lim, 8'h0});
		wr(`OFS_CONTROL, {26'h0, duty[1:0], `MODE_PWM});
		wr(`OFS_DUTY_HIGH, {24'h0, duty[9:2]});
		wr(`OFS_FLAGS, 32'h1 << n);
		wr(tmr(n), {16'h0, lim, 5'h0, 1'b1, ps});
		q = 32'h0;
		for (int k = 0; k < 300 && q[n] !== 1'b1; k++)
			rd(`OFS_FLAGS, q);
		check("match flag", 32'(q[n]), 32'h1);
		wr(`OFS_DIR, 32'h0);
		repeat (2) @(posedge clk);
		check("pin enable", 32'(pwm_oe), 32'h1);
	endtask : setup

	task automatic count_high(input int n, output int h);
		h = 0;
		repeat (n)
		begin
			@(posedge clk);
			if (pin === 1'b1)
				h++;
		end
	endtask : count_high

	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// Hang guard; the whole run needs well under a quarter of this
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fails++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		logic [31:0] q;
		logic [31:0] q2;
		logic [7:0]  lim;
		logic [9:0]  duty;
		logic [1:0]  ps;
		logic        hold;
		int          per;
		rst(10);
		check("pin enable", 32'(pwm_oe), 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			rd(ra[i], q);
			check("reset value", q, rv[i]);
		end
		// Every prescale and every timer, random limit and duty
		for (int i = 0; i < 6; i++)
		begin
			ps = (i < 3) ? 2'(i) : 2'($unsigned($random(seed)) % 4);
			lim = 8'($unsigned($random(seed)) % 4);
			duty = 10'(1 + $unsigned($random(seed)) % (4 * (lim + 1) - 2));
			per = exp_period(lim, ps);
			setup(2'(i % 3), ps, lim, duty);
			repeat (3 * per + 8) @(posedge clk);
			check("period", period_seen, per);
			if (ps == 2'h0)
				check("high time", high_seen, duty + 1);
		end
		// Zero duty never raises the pin
		setup(2'h0, 2'h0, 8'h1, 10'h0);
		count_high(24, per);
		check("zero duty", per, 0);
		// A pulse longer than the period is never cleared
		setup(2'h1, 2'h0, 8'h0, 10'h008);
		repeat (8) @(posedge clk);
		count_high(12, per);
		check("long pulse", per, 12);
		wr(`OFS_CONTROL, 32'h3);
		repeat (4) @(posedge clk);
		count_high(12, per);
		check("other mode", per, 0);
		wr(`OFS_CONTROL, 32'h0);
		repeat (2) @(posedge clk);
		check("pin release", 32'(pwm_oe), 32'h0);
		// Duty change just after a wrap, far from the next one
		setup(2'h2, 2'h2, 8'h3, 10'h008);
		while (pin !== 1'b0) @(posedge clk);
		while (pin !== 1'b1) @(posedge clk);
		wr(`OFS_DUTY_HIGH, 32'h5);
		rd(`OFS_DUTY_BUF, q);
		check("buffer hold", q, 32'h2);
		wr(`OFS_DUTY_BUF, 32'hFF);
		rd(`OFS_DUTY_BUF, q);
		check("buffer read only", q, 32'h2);
		// Sleep freezes the count and the pin level
		sleep <= 1'b1;
		rd(tmr(2'h2), q);
		hold = pin;
		repeat (40) @(posedge clk);
		rd(tmr(2'h2), q2);
		check("sleep count", q2[23:16], q[23:16]);
		check("sleep pin", 32'(pin), 32'(hold));
		// Clock enable low freezes the pin longer than any level lasts
		sleep <= 1'b0;
		ce    <= 1'b0;
		hold  = pin;
		count_high(200, per);
		check("stall pin", per, 200 * hold);
		ce    <= 1'b1;
		repeat (300) @(posedge clk);
		rd(`OFS_DUTY_BUF, q);
		check("buffer update", q, 32'h5);
		end_of_test();
	end
endmodule : standard_pwm_channel_tb_top
